// [pmsc_top.sv]
// APB register block for power management events and general feature control
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - A change of link state sets the link-change bit, and a written one clears it.
// - A received wake frame sets the wake-frame bit regardless of any wake enable, and a written one clears it.
// - A frame matching the wake filters sets the filter-match bit, and a written one clears it.
// - While software holds the management-ready bit set, the ready output to the management controller is active.
// - The read-only management-request bit reads one while the device is busy with management frames.
// - The wake-status bit mirrors the bus PME status and is set by any wake event regardless of PME enable.
// - On the earlier generation a written one clears wake status, bus PME status and PME; zero does nothing.
// - On the later generation the event register is reset only by the auxiliary reset, not by bus reset.
// - With deep power-down set and the link down in D2 or D3, the device may enter deep low power.
// - With clock-run disable set the device requests the bus clock continuously.
module pmsc_top
   import pmsc_pkg::*;
#(
   parameter bit LATER_GEN = 1'b1      // 1: later generation, 0: earlier generation
)
(
   input wire logic clk_sys,           // System clock, 200 MHz
   input wire logic rst_n,             // Bus reset, asynchronous, active low
   input wire logic aux_rst_n,         // Auxiliary reset, asynchronous, active low
   input wire logic psel,              // APB select
   input wire logic penable,           // APB enable
   input wire logic pwrite,            // APB direction
   input wire logic [7:0] paddr,       // APB byte address
   input wire logic [31:0] pwdata,     // APB write data
   input wire logic [3:0] pstrb,       // APB byte strobes
   output logic pready,                // APB ready
   output logic [31:0] prdata,         // APB read data
   output logic pslverr,               // APB error on unmapped address
   input wire logic link_up,           // Link state level
   input wire logic wake_frame_rx,     // Wake frame received pulse
   input wire logic filter_match,      // Wake filter hit pulse
   input wire logic wake_event,        // Any wake-up event pulse
   input wire logic pmcsr_pme_status,  // Bus power-management PME status
   input wire logic mgmt_busy,         // Busy with management frames
   input wire logic mgmt_force_flag,   // Forced management indication
   input wire logic [1:0] power_state, // Current device power state
   input wire logic core_clk_req,      // Clock request from the core
   output logic mgmt_ready,            // Ready to management controller
   output logic pme_status,            // Wake status bit
   output logic pme_clear,             // Clear pulse for bus PME status and PME
   output logic deep_pd_allow,         // Deep low-power state allowed
   output logic clk_req,               // Bus clock request
   output logic irq                    // Interrupt, active high level
);
   logic pwr_rst_n;
   logic link_chg;
   logic acc_wr;
   logic setup_rd;
   logic wr_lane0;
   logic hit_pwr;
   logic hit_ctrl;
   logic hit_istat;
   logic hit_imask;
   logic hit_any;
   logic [PMSC_EV_W-1:0] ev_set;
   logic [PMSC_EV_W-1:0] ev_clr;
   logic [PMSC_EV_W-1:0] ev_q;
   logic [PMSC_EV_W-1:0] irq_clr;
   logic [PMSC_EV_W-1:0] irq_q;
   logic [PMSC_EV_W-1:0] wake_clr_mask;
   logic [7:0] pwr_view;
   logic [7:0] ctrl_view;
   logic [31:0] rd_mux;
   logic ready_r;
   logic ready_nxt;
   logic [1:0] ctrl_r;
   logic [1:0] ctrl_nxt;
   logic [3:0] mask_r;
   logic [3:0] mask_nxt;
   logic [31:0] prdata_r;
   logic pme_clear_r;

   // Event register reset source depends on generation
   assign pwr_rst_n = LATER_GEN ? aux_rst_n : (aux_rst_n & rst_n);

   // APB decode, zero wait state
   assign acc_wr = psel & penable & pwrite;
   assign setup_rd = psel & ~penable & ~pwrite;
   assign wr_lane0 = acc_wr & pstrb[0];
   assign hit_pwr = (paddr == PMSC_OFS_PWR_EVENT);
   assign hit_ctrl = (paddr == PMSC_OFS_GEN_CTRL);
   assign hit_istat = (paddr == PMSC_OFS_IRQ_STAT);
   assign hit_imask = (paddr == PMSC_OFS_IRQ_MASK);
   assign hit_any = hit_pwr | hit_ctrl | hit_istat | hit_imask;
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~hit_any;

   // Link change detection
   pmsc_edge_det u_link_chg
   (
      .clk_sys(clk_sys),
      .rst_n(pwr_rst_n),
      .level_i(link_up),
      .change_o(link_chg)
   );

   // Event sources into the event register
   assign ev_set[PMSC_EV_LINK] = link_chg;
   assign ev_set[PMSC_EV_WFRAME] = wake_frame_rx;
   assign ev_set[PMSC_EV_FILTER] = filter_match;
   assign ev_set[PMSC_EV_WAKE] = wake_event | pmcsr_pme_status;

   // Write-one clears; wake status only on the earlier generation
   assign wake_clr_mask = {3'h7, ~LATER_GEN};
   assign ev_clr[PMSC_EV_LINK] = wr_lane0 & hit_pwr & pwdata[PMSC_BIT_LINK_CHG];
   assign ev_clr[PMSC_EV_WFRAME] = wr_lane0 & hit_pwr & pwdata[PMSC_BIT_WAKE_FRAME];
   assign ev_clr[PMSC_EV_FILTER] = wr_lane0 & hit_pwr & pwdata[PMSC_BIT_FILTER_HIT];
   assign ev_clr[PMSC_EV_WAKE] = wr_lane0 & hit_pwr & pwdata[PMSC_BIT_WAKE_STAT] & wake_clr_mask[0];

   pmsc_sticky #(.WIDTH(PMSC_EV_W)) u_events
   (
      .clk_sys(clk_sys),
      .rst_n(pwr_rst_n),
      .set_i(ev_set),
      .clr_i(ev_clr),
      .q_o(ev_q)
   );

   // Interrupt status, same events, write one to clear
   assign irq_clr = (wr_lane0 & hit_istat) ? pwdata[PMSC_EV_W-1:0] : '0;

   pmsc_sticky #(.WIDTH(PMSC_EV_W)) u_irq_stat
   (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .set_i(ev_set),
      .clr_i(irq_clr),
      .q_o(irq_q)
   );
   assign irq = |(irq_q & mask_r);

   // Writable fields; other bits are dropped
   assign ready_nxt = (wr_lane0 & hit_pwr) ? pwdata[PMSC_BIT_MGMT_READY] : ready_r;
   assign ctrl_nxt = (wr_lane0 & hit_ctrl) ? pwdata[1:0] : ctrl_r;
   assign mask_nxt = (wr_lane0 & hit_imask) ? pwdata[3:0] : mask_r;

   // Management ready lives with the event register
   always_ff @(posedge clk_sys or negedge pwr_rst_n)
   begin
      if (!pwr_rst_n)
      begin
         ready_r <= PMSC_RST_PWR_EVENT[PMSC_BIT_MGMT_READY];
      end
      else
      begin
         ready_r <= ready_nxt;
      end
   end

   // Control and mask registers on bus reset
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl_r <= PMSC_RST_GEN_CTRL[1:0];
         mask_r <= PMSC_RST_IRQ_MASK;
      end
      else
      begin
         ctrl_r <= ctrl_nxt;
         mask_r <= mask_nxt;
      end
   end

   // Read views with reserved bits at zero
   assign pwr_view = {ev_q[PMSC_EV_LINK], ev_q[PMSC_EV_WFRAME], ev_q[PMSC_EV_FILTER], 1'b0,
                      ready_r, mgmt_force_flag, mgmt_busy, ev_q[PMSC_EV_WAKE]};
   assign ctrl_view = {6'h00, ctrl_r};
   assign rd_mux = hit_pwr ? {24'h000000, pwr_view} :
                   hit_ctrl ? {24'h000000, ctrl_view} :
                   hit_istat ? {28'h0000000, irq_q} :
                   hit_imask ? {28'h0000000, mask_r} : 32'h00000000;

   // Read data captured in the setup cycle, PME clear pulse
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         prdata_r <= 32'h00000000;
         pme_clear_r <= 1'b0;
      end
      else
      begin
         prdata_r <= setup_rd ? rd_mux : prdata_r;
         pme_clear_r <= ev_clr[PMSC_EV_WAKE];
      end
   end
   assign prdata = prdata_r;
   assign pme_clear = pme_clear_r;

   // Device-side outputs
   assign mgmt_ready = ready_r;
   assign pme_status = ev_q[PMSC_EV_WAKE];
   assign deep_pd_allow = ctrl_r[PMSC_BIT_DEEP_PD] & ~link_up &
                          ((power_state == PMSC_DSTATE_D2) | (power_state == PMSC_DSTATE_D3));
   assign clk_req = ctrl_r[PMSC_BIT_CLKRUN_DIS] | core_clk_req;

   // Checks
   sequence s_pwr_w1(int b);
      psel && penable && pwrite && pstrb[0] && hit_pwr && pwdata[b];
   endsequence

   a_link_chg_set: assert property (@(posedge clk_sys) disable iff (!pwr_rst_n)
      link_chg |=> ev_q[PMSC_EV_LINK])
      else $error("link change not recorded");
   a_link_chg_clr: assert property (@(posedge clk_sys) disable iff (!pwr_rst_n)
      (s_pwr_w1(PMSC_BIT_LINK_CHG) and !link_chg) |=> !ev_q[PMSC_EV_LINK])
      else $error("link change bit not cleared");
   a_wframe_set: assert property (@(posedge clk_sys) disable iff (!pwr_rst_n)
      wake_frame_rx |=> ev_q[PMSC_EV_WFRAME])
      else $error("wake frame not recorded");
   a_filter_hold: assert property (@(posedge clk_sys) disable iff (!pwr_rst_n)
      (ev_q[PMSC_EV_FILTER] && !ev_clr[PMSC_EV_FILTER]) |=> ev_q[PMSC_EV_FILTER])
      else $error("filter bit lost without clear");
   a_ready_out: assert property (@(posedge clk_sys) disable iff (!pwr_rst_n)
      (s_pwr_w1(PMSC_BIT_MGMT_READY)) |=> mgmt_ready [*1])
      else $error("ready output not following write");
   a_req_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (setup_rd && hit_pwr) |=> (prdata[PMSC_BIT_MGMT_REQ] == $past(mgmt_busy)))
      else $error("request bit not reflecting busy");
   a_wake_set: assert property (@(posedge clk_sys) disable iff (!pwr_rst_n)
      (wake_event || pmcsr_pme_status) |=> pme_status)
      else $error("wake status not set");
   a_wake_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (s_pwr_w1(PMSC_BIT_WAKE_STAT) and !ev_set[PMSC_EV_WAKE]) |=> (pme_status == LATER_GEN) or !$past(pme_status))
      else $error("wake status clear wrong for generation");
   a_pme_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
      pme_clear |-> (!LATER_GEN && $past(ev_clr[PMSC_EV_WAKE])))
      else $error("PME clear pulse without cause");
   a_deep_pd: assert property (@(posedge clk_sys) disable iff (!rst_n)
      deep_pd_allow |-> (!link_up && ctrl_r[PMSC_BIT_DEEP_PD] && power_state[1]))
      else $error("deep power-down outside allowed state");
   a_clk_req: assert property (@(posedge clk_sys) disable iff (!rst_n)
      ctrl_r[PMSC_BIT_CLKRUN_DIS] |-> clk_req)
      else $error("clock request dropped with clock-run disabled");
   a_rsvd_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (setup_rd && hit_ctrl) |=> (prdata[31:2] == 30'h00000000))
      else $error("reserved control bits not zero");
   a_irq_level: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (|(ev_set & mask_r) && !(wr_lane0 && hit_imask)) |=> irq)
      else $error("interrupt not raised for an unmasked event");
endmodule : pmsc_top
`default_nettype wire

// [pmsc_pkg.sv]
// Register map, field positions and reset values of the power management status block
package pmsc_pkg;
   // Byte addresses of the registers
   localparam logic [7:0] PMSC_OFS_PWR_EVENT = 8'h18;
   localparam logic [7:0] PMSC_OFS_GEN_CTRL = 8'h1c;
   localparam logic [7:0] PMSC_OFS_IRQ_STAT = 8'h20;
   localparam logic [7:0] PMSC_OFS_IRQ_MASK = 8'h24;
   // Field positions in power_event_driver_status
   localparam int PMSC_BIT_LINK_CHG = 7;
   localparam int PMSC_BIT_WAKE_FRAME = 6;
   localparam int PMSC_BIT_FILTER_HIT = 5;
   localparam int PMSC_BIT_MGMT_READY = 3;
   localparam int PMSC_BIT_MGMT_FORCE = 2;
   localparam int PMSC_BIT_MGMT_REQ = 1;
   localparam int PMSC_BIT_WAKE_STAT = 0;
   // Field positions in general_feature_control
   localparam int PMSC_BIT_DEEP_PD = 1;
   localparam int PMSC_BIT_CLKRUN_DIS = 0;
   // Event index in the sticky event and interrupt vectors
   localparam int PMSC_EV_LINK = 3;
   localparam int PMSC_EV_WFRAME = 2;
   localparam int PMSC_EV_FILTER = 1;
   localparam int PMSC_EV_WAKE = 0;
   localparam int PMSC_EV_W = 4;
   // Reset values
   localparam logic [7:0] PMSC_RST_PWR_EVENT = 8'h00;
   localparam logic [7:0] PMSC_RST_GEN_CTRL = 8'h00;
   localparam logic [3:0] PMSC_RST_IRQ_MASK = 4'h0;
   // Power states where deep power-down is allowed
   localparam logic [1:0] PMSC_DSTATE_D2 = 2'h2;
   localparam logic [1:0] PMSC_DSTATE_D3 = 2'h3;
endpackage : pmsc_pkg

// [pmsc_sticky.sv]
// Sticky event bits: set by hardware, cleared by a write of one, set wins
`timescale 1ns/1ps
`default_nettype none
module pmsc_sticky
#(
   parameter int WIDTH = 4
)
(
   input wire logic clk_sys,             // System clock
   input wire logic rst_n,               // Asynchronous reset, active low
   input wire logic [WIDTH-1:0] set_i,   // Event pulses
   input wire logic [WIDTH-1:0] clr_i,   // Clear pulses
   output logic [WIDTH-1:0] q_o          // Sticky state
);
   logic [WIDTH-1:0] q_r;
   logic [WIDTH-1:0] q_nxt;

   // A set in the clearing cycle keeps the bit
   assign q_nxt = set_i | (q_r & ~clr_i);
   assign q_o = q_r;

   // State flops
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         q_r <= '0;
      end
      else
      begin
         q_r <= q_nxt;
      end
   end
endmodule : pmsc_sticky
`default_nettype wire

// [pmsc_edge_det.sv]
// Change detector for a level, quiet in the first cycle after reset
`timescale 1ns/1ps
`default_nettype none
module pmsc_edge_det
(
   input wire logic clk_sys,  // System clock
   input wire logic rst_n,    // Asynchronous reset, active low
   input wire logic level_i,  // Level to watch
   output logic change_o      // One-cycle pulse on any change
);
   logic last_r;
   logic seen_r;

   // Compare only once a reference value has been captured
   assign change_o = seen_r & (level_i ^ last_r);

   // Reference capture
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         last_r <= 1'b0;
         seen_r <= 1'b0;
      end
      else
      begin
         last_r <= level_i;
         seen_r <= 1'b1;
      end
   end
endmodule : pmsc_edge_det
`default_nettype wire

// [pmsc_far_model.sv]
// Far-side model: link, wake sources and the management controller
`timescale 1ns/1ps
`default_nettype none
module pmsc_far_model
(
   input wire logic clk_sys,        // System clock
   input wire logic mgmt_ready,     // Ready from the device
   output var logic link_up,        // Link level
   output var logic wake_frame_rx,  // Wake frame pulse
   output var logic filter_match,   // Filter hit pulse
   output var logic wake_event,     // Wake event pulse
   output var logic pmcsr_pme_status, // Bus PME status level
   output var logic mgmt_busy,      // Management traffic busy
   output var logic mgmt_force_flag, // Forced management indication
   output var logic [1:0] power_state, // Device power state
   output var logic core_clk_req    // Core clock request
);
   // Quiet idle levels at time zero
   initial
   begin
      {link_up, wake_frame_rx, filter_match, wake_event, pmcsr_pme_status} = 5'h00;
      {mgmt_busy, mgmt_force_flag, power_state, core_clk_req} = 5'h00;
   end
   // One-cycle event: 0 wake, 1 filter, 2 wake frame, 3 link toggle
   task automatic pulse(input int k);
      @(posedge clk_sys);
      case (k)
         0: wake_event <= 1'b1;
         1: filter_match <= 1'b1;
         2: wake_frame_rx <= 1'b1;
         default: link_up <= !link_up;
      endcase
      @(posedge clk_sys);
      {wake_event, filter_match, wake_frame_rx} <= 3'h0;
   endtask : pulse
   // Controller only starts a cycle while the device says ready
   task automatic set_busy(input logic b);
      @(posedge clk_sys);
      mgmt_busy <= b & mgmt_ready;
   endtask : set_busy
   // Bus PME status level
   task automatic set_pme(input logic p);
      @(posedge clk_sys);
      pmcsr_pme_status <= p;
   endtask : set_pme
   // Static levels
   task automatic set_lvl(input logic lk, input logic frc, input logic [1:0] ps, input logic cr);
      @(posedge clk_sys);
      link_up <= lk;
      mgmt_force_flag <= frc;
      power_state <= ps;
      core_clk_req <= cr;
   endtask : set_lvl
endmodule : pmsc_far_model
`default_nettype wire

// [power_mgmt_status_control_bench.sv]
// Self-checking bench for the power management register block
`timescale 1ns/1ps
`default_nettype none
module power_mgmt_status_control_bench;
   logic clk_sys, rst_n, aux_rst_n, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic [3:0] pstrb;
   logic link_up, wake_frame_rx, filter_match, wake_event, pmcsr_pme_status, mgmt_busy, mgmt_force_flag;
   logic [1:0] power_state;
   logic core_clk_req, mgmt_ready, pme_status, pme_clear, deep_pd_allow, clk_req, irq, rerr;
   logic [31:0] prdata_e, rdat_e;
   logic pme_status_e, pme_clear_e;
   int fail_count = 0;
   int samples_checked = 0;
   logic [7:0] ev_bit [3] = '{8'h20, 8'h40, 8'h80};
   pmsc_top #(.LATER_GEN(1'b1)) pmsc_top_i (.clk_sys(clk_sys), .rst_n(rst_n), .aux_rst_n(aux_rst_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .pready(pready), .prdata(prdata), .pslverr(pslverr), .link_up(link_up), .wake_frame_rx(wake_frame_rx),
      .filter_match(filter_match), .wake_event(wake_event), .pmcsr_pme_status(pmcsr_pme_status),
      .mgmt_busy(mgmt_busy), .mgmt_force_flag(mgmt_force_flag), .power_state(power_state),
      .core_clk_req(core_clk_req), .mgmt_ready(mgmt_ready), .pme_status(pme_status), .pme_clear(pme_clear),
      .deep_pd_allow(deep_pd_allow), .clk_req(clk_req), .irq(irq));
   // Earlier generation twin on the same bus and far side
   pmsc_top #(.LATER_GEN(1'b0)) pmsc_top_early_i (.clk_sys(clk_sys), .rst_n(rst_n), .aux_rst_n(aux_rst_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .pready(), .prdata(prdata_e), .pslverr(), .link_up(link_up), .wake_frame_rx(wake_frame_rx),
      .filter_match(filter_match), .wake_event(wake_event), .pmcsr_pme_status(pmcsr_pme_status),
      .mgmt_busy(mgmt_busy), .mgmt_force_flag(mgmt_force_flag), .power_state(power_state),
      .core_clk_req(core_clk_req), .mgmt_ready(), .pme_status(pme_status_e), .pme_clear(pme_clear_e),
      .deep_pd_allow(), .clk_req(), .irq());
   pmsc_far_model pmsc_far_model_i (.clk_sys(clk_sys), .mgmt_ready(mgmt_ready), .link_up(link_up),
      .wake_frame_rx(wake_frame_rx), .filter_match(filter_match), .wake_event(wake_event),
      .pmcsr_pme_status(pmcsr_pme_status), .mgmt_busy(mgmt_busy), .mgmt_force_flag(mgmt_force_flag),
      .power_state(power_state), .core_clk_req(core_clk_req));
   // 200 MHz clock
   initial
   begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = !clk_sys;
   end
   // Compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // One APB transfer, held until pready is seen high
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      rdat = prdata;
      rdat_e = prdata_e;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk(rdat, exp);
   endtask : rdc
   // Pulse one reset line for two cycles
   task automatic pulse_rst(input logic aux);
      @(posedge clk_sys);
      if (aux) aux_rst_n <= 1'b0; else rst_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      aux_rst_n <= 1'b1;
   endtask : pulse_rst
   task automatic stop_test;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : stop_test
   // Hang guard
   initial
   begin
      repeat (4000) @(posedge clk_sys);
      fail_count++;
      stop_test();
   end
   // Main sequence
   initial
   begin
      {rst_n, aux_rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
      pstrb = 4'h1;
      repeat (6) @(posedge clk_sys);
      rst_n <= 1'b1;
      aux_rst_n <= 1'b1;
      rdc(8'h18, 32'h0);
      rdc(8'h1c, 32'h0);
      rdc(8'h30, 32'h0);
      chk(rerr, 1'b1);
      wr(8'h24, 32'hf);
      rdc(8'h24, 32'hf);
      // Filter hit, wake frame and link change: set, interrupt, clear
      for (int k = 0; k < 3; k++)
      begin
         pmsc_far_model_i.pulse(k + 1);
         rdc(8'h18, ev_bit[k]);
         chk(irq, 1'b1);
         rdc(8'h20, 32'h1 << (k + 1));
         wr(8'h18, ev_bit[k]);
         wr(8'h20, 32'hf);
         rdc(8'h18, 32'h0);
         rdc(8'h20, 32'h0);
         chk(irq, 1'b0);
      end
      // Wake status is not write-clearable on the later generation
      pmsc_far_model_i.pulse(0);
      rdc(8'h18, 32'h01);
      chk(rdat_e, 32'h01);
      // Earlier generation: a written zero keeps wake status, a written one clears it and pulses PME clear
      wr(8'h18, 32'h00);
      @(posedge clk_sys);
      chk({pme_status_e, pme_clear_e}, 2'b10);
      wr(8'h18, 32'h01);
      @(posedge clk_sys);
      chk({pme_status_e, pme_clear_e}, 2'b01);
      rdc(8'h18, 32'h01);
      chk({pme_status, pme_clear}, 2'b10);
      wr(8'h18, 32'hf6);
      rdc(8'h18, 32'h01);
      wr(8'h18, 32'h08);
      rdc(8'h18, 32'h09);
      chk(mgmt_ready, 1'b1);
      pmsc_far_model_i.set_busy(1'b1);
      pmsc_far_model_i.set_lvl(1'b1, 1'b1, 2'h0, 1'b0);
      rdc(8'h18, 32'h0f);
      pmsc_far_model_i.set_busy(1'b0);
      // Bus reset leaves the later generation's event register alone and clears the earlier one's, auxiliary reset clears it
      pulse_rst(1'b0);
      rdc(8'h18, 32'h0d);
      chk(rdat_e, 32'h04);
      rdc(8'h24, 32'h0);
      pulse_rst(1'b1);
      rdc(8'h18, 32'h04);
      chk(mgmt_ready, 1'b0);
      // Bus PME status level keeps wake status set, even against a clearing write
      pmsc_far_model_i.set_pme(1'b1);
      wr(8'h18, 32'h01);
      rdc(8'h18, 32'h05);
      chk(rdat_e, 32'h05);
      pmsc_far_model_i.set_pme(1'b0);
      // General control
      wr(8'h1c, 32'hff);
      rdc(8'h1c, 32'h03);
      chk(clk_req, 1'b1);
      pmsc_far_model_i.set_lvl(1'b0, 1'b0, 2'h3, 1'b0);
      @(posedge clk_sys);
      chk(deep_pd_allow, 1'b1);
      pmsc_far_model_i.set_lvl(1'b0, 1'b0, 2'h1, 1'b0);
      @(posedge clk_sys);
      chk(deep_pd_allow, 1'b0);
      wr(8'h1c, 32'h0);
      @(posedge clk_sys);
      chk(clk_req, 1'b0);
      stop_test();
   end
endmodule : power_mgmt_status_control_bench
`default_nettype wire
